// ### design/sumg_pkg.sv
// Package with constants for the sync and descriptor message generator.
package sumg_pkg;
	localparam int unsigned clk_mhz = 100;
	localparam int unsigned ts_width = 32;
	localparam logic [1:0] fc_kind_mac_specific = 2'h3;
	localparam logic [4:0] fc_param_timing = 5'h00;
	localparam logic [7:0] sync_msg_type = 8'h01;
	localparam logic [7:0] sync_msg_version = 8'h01;
	localparam int unsigned sync_len = 8;
	localparam int unsigned mpeg_pkt_len = 188;
	localparam int unsigned mpeg_hdr_len = 4;
	localparam logic [7:0] ucd_type_t12 = 8'h02;
	localparam logic [7:0] ucd_ver_t12 = 8'h01;
	localparam logic [7:0] ucd_type_t3 = 8'h1d;
	localparam logic [7:0] ucd_ver_t3 = 8'h03;
	localparam logic [7:0] ucd_type_t4 = 8'h23;
	localparam logic [7:0] ucd_ver_t4 = 8'h04;
	localparam logic [7:0] ucd_type_t5 = 8'h33;
	localparam logic [7:0] ucd_ver_t5 = 8'h05;
	localparam logic [7:0] burst_tlv4 = 8'h04;
	localparam logic [7:0] burst_tlv5 = 8'h05;
	localparam logic [7:0] burst_tlv23 = 8'h17;
	localparam logic [7:0] chan_tlv_shared29 = 8'h16;
	localparam logic [7:0] chan_tlv_shared35 = 8'h14;
	localparam logic [7:0] shared29_value = 8'h01;
	localparam logic [7:0] tlv_len_one = 8'h01;
	localparam logic [3:0] iuc_request = 4'h1;
	localparam logic [3:0] iuc_init_rng = 4'h3;
	localparam logic [3:0] iuc_short = 4'h5;
	localparam logic [3:0] iuc_long = 4'h6;
	localparam logic [3:0] iuc_adv_short = 4'h9;
	localparam logic [3:0] iuc_adv_long = 4'ha;
	localparam logic [3:0] iuc_adv_ugs = 4'hb;
	localparam logic [2:0] chan_type1 = 3'h1;
	localparam logic [2:0] chan_type2 = 3'h2;
	localparam logic [2:0] chan_type3 = 3'h3;
	localparam logic [2:0] chan_type4 = 3'h4;
	localparam logic [2:0] chan_type5 = 3'h5;
endpackage

// ### design/sumg_ts_counter.sv
// Free-running timestamp counter on the master clock enable.
`timescale 1ns/1ps
module sumg_ts_counter #(
	parameter int unsigned width = 32
)(
	input wire logic clock, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic tick, // One master clock edge seen.
	output logic [width-1:0] count // Counter value, registered.
);
	// Counts every master tick and wraps through zero with no gap.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			count <= '0;
		else if (tick)
			count <= count + 1'b1;
	end

	chk_wrap_no_gap: assert property (@(posedge clock) disable iff (sys_rst)
		tick |=> count == $past(count) + 1'b1) else $error("timestamp skipped");
endmodule // sumg_ts_counter

// ### design/sumg_msg_gen.sv
// Sync and upstream descriptor message byte generator.
`timescale 1ns/1ps
module sumg_msg_gen #(
	parameter int unsigned sync_period = 1000, // Cycles between sync messages.
	parameter int unsigned ucd_period = 2000, // Cycles between descriptor rounds.
	parameter int unsigned num_us = 4, // Logical upstream channels.
	parameter int unsigned master_div = 10 // System cycles per master tick approx.
)(
	input wire logic clock, // System clock 100 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic primary_capable, // Downstream channel may carry sync.
	input wire logic [num_us-1:0] us_available, // Upstream channel in service.
	input wire logic [num_us-1:0] us_maps_here, // Maps of channel go on this downstream.
	input wire logic [num_us*3-1:0] us_chan_type, // Channel type per upstream.
	input wire logic [num_us-1:0] us_shared, // Channel also described by pair.
	input wire logic [7:0] change_count, // Shared change count, as in the map.
	input wire logic [7:0] shared35_value, // Value for the type 35 pair TLV.
	input wire logic [7:0] mpeg_pos, // Byte position in current transport packet.
	input wire logic out_ready, // Physical sublayer takes a byte.
	output logic [7:0] out_data, // Message byte.
	output logic out_valid, // Byte valid.
	output logic out_first, // First byte of a message.
	output logic out_last, // Last byte of a message.
	output logic [1:0] frame_control_kind, // Frame control kind of current message.
	output logic [4:0] frame_control_param, // Frame control parameter of current message.
	output logic [7:0] upstream_chan_ident // Upstream channel of current descriptor.
);
	localparam int unsigned us_bits = (num_us > 1) ? $clog2(num_us) : 1;
	localparam int unsigned ucd_len = 16;
	localparam int unsigned lead_slots = 2; // Open slots that may pass before the first sync byte leaves.

	// -----------------------------------------------------------
	// Types and decoding
	// -----------------------------------------------------------
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_sync = 3'b010,
		st_ucd = 3'b100
	} sumg_state_t;

	// Message type and version for a channel type.
	function automatic logic [15:0] type_version(input logic [2:0] ct);
		case (ct)
			sumg_pkg::chan_type5: type_version = {sumg_pkg::ucd_type_t5, sumg_pkg::ucd_ver_t5};
			sumg_pkg::chan_type4: type_version = {sumg_pkg::ucd_type_t4, sumg_pkg::ucd_ver_t4};
			sumg_pkg::chan_type3: type_version = {sumg_pkg::ucd_type_t3, sumg_pkg::ucd_ver_t3};
			default: type_version = {sumg_pkg::ucd_type_t12, sumg_pkg::ucd_ver_t12};
		endcase
	endfunction

	// Burst TLV kind and interval usage code per channel type and slot.
	function automatic logic [11:0] burst_slot(input logic [2:0] ct, input logic [1:0] slot);
		logic [7:0] kind;
		logic [3:0] iuc;
		kind = sumg_pkg::burst_tlv5;
		iuc = sumg_pkg::iuc_request;
		case (ct)
			sumg_pkg::chan_type5:
			begin
				kind = sumg_pkg::burst_tlv23;
				iuc = (slot == 2'h0) ? sumg_pkg::iuc_request : sumg_pkg::iuc_adv_short;
			end
			sumg_pkg::chan_type4:
				iuc = (slot == 2'h0) ? sumg_pkg::iuc_short : (slot == 2'h1) ? sumg_pkg::iuc_long :
					(slot == 2'h2) ? sumg_pkg::iuc_adv_short : sumg_pkg::iuc_adv_long;
			sumg_pkg::chan_type3:
				iuc = (slot == 2'h0) ? sumg_pkg::iuc_init_rng : (slot == 2'h1) ? sumg_pkg::iuc_request :
					sumg_pkg::iuc_adv_short;
			default:
			begin
				kind = (slot == 2'h3 && ct == sumg_pkg::chan_type2) ? sumg_pkg::burst_tlv5 :
					sumg_pkg::burst_tlv4;
				iuc = (slot == 2'h0) ? sumg_pkg::iuc_request : (slot == 2'h1) ? sumg_pkg::iuc_short :
					(slot == 2'h2) ? sumg_pkg::iuc_long : sumg_pkg::iuc_adv_short;
			end
		endcase
		burst_slot = {kind, iuc};
	endfunction

	// -----------------------------------------------------------
	// Timebase and timers
	// -----------------------------------------------------------
	logic [3:0] div_cnt;
	logic tick;
	logic [31:0] ts_count;
	logic [31:0] sync_timer;
	logic [31:0] ucd_timer;
	logic sync_due;
	logic ucd_due;
	sumg_state_t state;
	logic [7:0] byte_idx;
	logic [us_bits-1:0] us_idx;
	logic [31:0] ts_hold;
	logic [2:0] cur_ct;
	logic [11:0] cur_burst;
	logic [15:0] cur_tv;
	logic [7:0] next_data;
	logic fits_packet;
	logic load;
	logic start_sync;
	logic start_ucd;
	logic round_end;

	// Master clock enable derived from the system clock.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			div_cnt <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (div_cnt == 4'(master_div - 1));
			div_cnt <= (div_cnt == 4'(master_div - 1)) ? '0 : div_cnt + 1'b1;
		end
	end

	sumg_ts_counter #(.width(sumg_pkg::ts_width)) u_ts (
		.clock(clock),
		.sys_rst(sys_rst),
		.tick(tick),
		.count(ts_count)
	);

	// Period timers raise sticky due flags that the sender consumes.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sync_timer <= '0;
			ucd_timer <= '0;
			sync_due <= 1'b0;
			ucd_due <= 1'b0;
		end
		else
		begin
			sync_timer <= (sync_timer == sync_period - 1) ? '0 : sync_timer + 1'b1;
			ucd_timer <= (ucd_timer == ucd_period - 1) ? '0 : ucd_timer + 1'b1;
			if (sync_timer == sync_period - 1)
				sync_due <= 1'b1;
			else if (state == st_sync && byte_idx == 8'(sumg_pkg::sync_len - 1) && load)
				sync_due <= 1'b0;
			if (ucd_timer == ucd_period - 1)
				ucd_due <= 1'b1;
			else if (round_end)
				ucd_due <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// Message sequencing
	// -----------------------------------------------------------
	assign cur_ct = us_chan_type[us_idx*3 +: 3];
	assign cur_tv = type_version(cur_ct);
	assign cur_burst = burst_slot(cur_ct, byte_idx[2:1]);
	// A byte enters the output stage when the sink takes one or the stage is empty; a round ends past the last channel.
	assign load = out_ready || !out_valid;
	assign fits_packet = (32'(mpeg_pos) >= sumg_pkg::mpeg_hdr_len) &&
		(32'(mpeg_pos) + sumg_pkg::sync_len + lead_slots <= sumg_pkg::mpeg_pkt_len);
	assign start_sync = sync_due && primary_capable && fits_packet;
	assign start_ucd = ucd_due && us_available[us_idx] && us_maps_here[us_idx];
	assign round_end = (us_idx == us_bits'(num_us - 1)) &&
		((state == st_ucd && load && byte_idx == 8'(ucd_len - 1)) ||
		(state == st_idle && ucd_due && !start_sync && !start_ucd));

	// State, byte index, channel index and timestamp capture.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state <= st_idle;
			byte_idx <= '0;
			us_idx <= '0;
			ts_hold <= '0;
		end
		else
		begin
			case (state)
				st_idle:
				begin
					byte_idx <= '0;
					if (start_sync)
					begin
						state <= st_sync;
						ts_hold <= ts_count;
					end
					else if (start_ucd)
						state <= st_ucd;
					else if (ucd_due)
						us_idx <= (us_idx == us_bits'(num_us - 1)) ? '0 : us_idx + 1'b1;
				end
				st_sync:
					if (load)
					begin
						byte_idx <= byte_idx + 1'b1;
						if (byte_idx == 8'(sumg_pkg::sync_len - 1))
							state <= st_idle;
					end
				st_ucd:
					if (load)
					begin
						byte_idx <= byte_idx + 1'b1;
						if (byte_idx == 8'(ucd_len - 1))
						begin
							state <= st_idle;
							us_idx <= (us_idx == us_bits'(num_us - 1)) ? '0 : us_idx + 1'b1;
						end
					end
				default:
					state <= st_idle;
			endcase
		end
	end

	// Byte content of the current message.
	always_comb
	begin
		next_data = 8'h00;
		if (state == st_sync)
		begin
			case (byte_idx[2:0])
				3'h0: next_data = sumg_pkg::sync_msg_type;
				3'h1: next_data = sumg_pkg::sync_msg_version;
				3'h4: next_data = ts_hold[31:24];
				3'h5: next_data = ts_hold[23:16];
				3'h6: next_data = ts_hold[15:8];
				3'h7: next_data = ts_hold[7:0];
				default: next_data = 8'h00;
			endcase
		end
		else if (state == st_ucd)
		begin
			case (byte_idx[3:0])
				4'h0: next_data = cur_tv[15:8];
				4'h1: next_data = cur_tv[7:0];
				4'h2: next_data = 8'(us_idx) + 8'h01;
				4'h3: next_data = change_count;
				4'h4: next_data = (cur_ct == sumg_pkg::chan_type4) ? sumg_pkg::chan_tlv_shared35 :
					sumg_pkg::chan_tlv_shared29;
				4'h5: next_data = sumg_pkg::tlv_len_one;
				4'h6: next_data = (cur_ct == sumg_pkg::chan_type4) ? shared35_value : sumg_pkg::shared29_value;
				4'h8, 4'ha, 4'hc, 4'he: next_data = cur_burst[11:4];
				4'h9, 4'hb, 4'hd, 4'hf: next_data = {4'h0, cur_burst[3:0]};
				default: next_data = 8'h00;
			endcase
			if (!us_shared[us_idx] && byte_idx[3:0] >= 4'h4 && byte_idx[3:0] <= 4'h6)
				next_data = 8'h00;
		end
	end

	// Registered output stage.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			out_data <= '0;
			out_valid <= 1'b0;
			out_first <= 1'b0;
			out_last <= 1'b0;
			frame_control_kind <= '0;
			frame_control_param <= '0;
			upstream_chan_ident <= '0;
		end
		else if (load)
		begin
			out_data <= next_data;
			out_valid <= (state != st_idle);
			out_first <= (state != st_idle) && byte_idx == 8'h00;
			out_last <= (state == st_sync && byte_idx == 8'(sumg_pkg::sync_len - 1)) ||
				(state == st_ucd && byte_idx == 8'(ucd_len - 1));
			frame_control_kind <= sumg_pkg::fc_kind_mac_specific;
			frame_control_param <= (state == st_sync) ? sumg_pkg::fc_param_timing : 5'h00;
			upstream_chan_ident <= 8'(us_idx) + 8'h01;
		end
	end

	// -----------------------------------------------------------
	// Checks
	// -----------------------------------------------------------
	sequence sync_start;
		state == st_idle ##1 state == st_sync;
	endsequence

	chk_sync_primary_only: assert property (@(posedge clock) disable iff (sys_rst)
		sync_start |-> $past(primary_capable)) else $error("sync on non primary");
	chk_sync_fits: assert property (@(posedge clock) disable iff (sys_rst)
		sync_start |-> $past(fits_packet)) else $error("sync crosses packet");
	chk_ts_capture: assert property (@(posedge clock) disable iff (sys_rst)
		sync_start |-> ts_hold == $past(ts_count)) else $error("timestamp not captured");
	chk_ucd_maps_here: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_idle ##1 state == st_ucd |-> $past(us_maps_here[us_idx] && us_available[us_idx]))
		else $error("descriptor on wrong channel");
	chk_type_t5: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_ucd && cur_ct == sumg_pkg::chan_type5 |-> cur_tv == 16'h3305) else $error("bad type 51");
	chk_type_t3: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_ucd && cur_ct == sumg_pkg::chan_type3 |-> cur_tv == 16'h1d03) else $error("bad type 29");
	chk_burst_t51: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_ucd && cur_ct == sumg_pkg::chan_type5 |-> cur_burst[11:4] == 8'h17)
		else $error("type 51 burst kind");
	chk_no_iuc56_t3: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_ucd && cur_ct == sumg_pkg::chan_type3 |-> cur_burst[3:0] != 4'h5 && cur_burst[3:0] != 4'h6)
		else $error("type 3 has codes 5 or 6");
	chk_t2_low_iuc: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_ucd && cur_ct <= sumg_pkg::chan_type2 && cur_burst[3:0] <= 4'h6
		|-> cur_burst[11:4] == 8'h04) else $error("type 2 low code as type 5");
	chk_sync_fc: assert property (@(posedge clock) disable iff (sys_rst)
		state == st_sync && out_ready ##1 1'b1 |-> frame_control_param == sumg_pkg::fc_param_timing)
		else $error("sync missing timing header");
endmodule // sumg_msg_gen

// ### verification/sumg_sink_model.sv
// Byte sink standing in for the physical sublayer that takes generated messages.
`timescale 1ns/1ps
module sumg_sink_model (
	input wire logic clock, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic slow, // Offer a byte slot on one cycle of three only.
	input wire logic [7:0] out_data, // Byte from the generator.
	input wire logic out_valid, // Byte valid.
	input wire logic out_first, // First byte of a message.
	input wire logic out_last, // Last byte of a message.
	output logic out_ready, // A byte slot is open this cycle.
	output logic [7:0] mpeg_pos, // Slot position in the transport packet.
	output logic [7:0] msg [0:15], // Bytes of the last complete message.
	output logic [4:0] msg_len, // Byte count of the last complete message.
	output logic msg_done // Pulses once a message is complete.
);
	logic [1:0] phase;
	logic [4:0] fill;

	// Slot pacing advances every cycle; the packet position advances only on open slots.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			phase <= 2'h0;
			mpeg_pos <= 8'h00;
		end
		else
		begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			if (out_ready)
				mpeg_pos <= (mpeg_pos == 8'hbb) ? 8'h00 : mpeg_pos + 8'h01;
		end
	end

	assign out_ready = !slow || (phase == 2'h0);

	// Collect the bytes of each message as they are taken.
	always_ff @(posedge clock)
	begin
		msg_done <= !sys_rst && out_valid && out_ready && out_last;
		if (sys_rst)
			fill <= 5'h00;
		else if (out_valid && out_ready)
		begin
			if (out_first)
			begin
				msg[0] <= out_data;
				fill <= 5'h01;
			end
			else if (fill < 5'h10)
			begin
				msg[fill[3:0]] <= out_data;
				fill <= fill + 5'h01;
			end
			if (out_last)
			begin
				msg_len <= out_first ? 5'h01 : fill + 5'h01;
			end
		end
	end
endmodule // sumg_sink_model

// ### verification/tb.sv
// Self-checking bench for the sync and descriptor message generator.
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic primary_capable = 1'b0;
	logic slow = 1'b0;
	logic in_sync = 1'b0;
	logic [3:0] us_available = 4'h0, us_maps_here = 4'h0, us_shared = 4'h0, seen, hint;
	logic [3:0][7:0] best;
	logic [11:0] us_chan_type = 12'h000;
	logic [7:0] change_count = 8'h00, shared35_value = 8'h00, lfsr = 8'h46;
	logic [7:0] mpeg_pos, out_data, id, upstream_chan_ident;
	logic [7:0] msg [0:15];
	logic out_ready, out_valid, out_first, out_last, msg_done;
	logic [1:0] frame_control_kind;
	logic [4:0] frame_control_param;
	logic [4:0] msg_len;
	logic [31:0] ts, prev_ts;
	int n_errors = 0, tests_run = 0, cycles = 0, n_sync = 0, first_cyc = 0, prev_cyc = -1;

	sumg_msg_gen #(.sync_period(50), .ucd_period(200), .num_us(4), .master_div(10)) dut_u (
		.clock(clock), .sys_rst(sys_rst), .primary_capable(primary_capable),
		.us_available(us_available), .us_maps_here(us_maps_here), .us_chan_type(us_chan_type),
		.us_shared(us_shared), .change_count(change_count), .shared35_value(shared35_value),
		.mpeg_pos(mpeg_pos), .out_ready(out_ready), .out_data(out_data), .out_valid(out_valid),
		.out_first(out_first), .out_last(out_last), .frame_control_kind(frame_control_kind),
		.frame_control_param(frame_control_param), .upstream_chan_ident(upstream_chan_ident));

	sumg_sink_model sink_u (
		.clock(clock), .sys_rst(sys_rst), .slow(slow), .out_data(out_data), .out_valid(out_valid),
		.out_first(out_first), .out_last(out_last), .out_ready(out_ready), .mpeg_pos(mpeg_pos),
		.msg(msg), .msg_len(msg_len), .msg_done(msg_done));

	// Clock at 100 MHz.
	initial
	begin
		forever #5 clock = ~clock;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Expected descriptor type and version for a channel type.
	function automatic logic [15:0] exp_hdr(input logic [2:0] ct);
		case (ct)
			sumg_pkg::chan_type5: return {sumg_pkg::ucd_type_t5, sumg_pkg::ucd_ver_t5};
			sumg_pkg::chan_type4: return {sumg_pkg::ucd_type_t4, sumg_pkg::ucd_ver_t4};
			sumg_pkg::chan_type3: return {sumg_pkg::ucd_type_t3, sumg_pkg::ucd_ver_t3};
			default: return {sumg_pkg::ucd_type_t12, sumg_pkg::ucd_ver_t12};
		endcase
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Judge one complete message from the sink.
	task automatic check_msg();
		logic [15:0] hdr;
		logic [15:0] codes;
		logic [23:0] pair;
		logic [7:0] t, k;
		logic [3:0] c;
		logic adv;
		int i, dt, dc;
		if (in_sync)
		begin
			n_sync++;
			check(msg_len, 8);
			check({msg[0], msg[1], msg[2], msg[3]}, {sumg_pkg::sync_msg_type, sumg_pkg::sync_msg_version, 16'h0});
			check(primary_capable, 1);
			ts = {msg[4], msg[5], msg[6], msg[7]};
			dt = ts - prev_ts;
			dc = first_cyc - prev_cyc;
			if (prev_cyc >= 0)
				check(dt >= dc * 100 / 1024 - 2 && dt <= dc / 10 + 2, 1);
			prev_ts = ts;
			prev_cyc = first_cyc;
			return;
		end
		i = int'(msg[2]) - 1;
		check(msg[2] >= 1 && msg[2] <= 4 && us_available[i[1:0]] && us_maps_here[i[1:0]], 1);
		seen[i[1:0]] = 1'b1;
		hdr = exp_hdr(us_chan_type[3 * i[1:0] +: 3]);
		t = hdr[15:8];
		if (t > best[i[1:0]])
			best[i[1:0]] = t;
		if (msg[4] == sumg_pkg::chan_tlv_shared29)
			hint[i[1:0]] = 1'b1;
		check(msg_len, 16);
		check({msg[0], msg[1]}, hdr);
		check({msg[2], msg[3]}, {id, change_count});
		pair = 24'h0;
		if (us_shared[i[1:0]] && t == sumg_pkg::ucd_type_t3)
			pair = {sumg_pkg::chan_tlv_shared29, sumg_pkg::tlv_len_one, sumg_pkg::shared29_value};
		if (us_shared[i[1:0]] && t == sumg_pkg::ucd_type_t4)
			pair = {sumg_pkg::chan_tlv_shared35, sumg_pkg::tlv_len_one, shared35_value};
		check({msg[4], msg[5], msg[6], msg[7]}, {pair, 8'h00});
		codes = 16'h0;
		adv = 1'b0;
		for (int j = 0; j < 4; j++)
		begin
			k = msg[8 + 2 * j];
			c = msg[9 + 2 * j][3:0];
			codes[c] = 1'b1;
			if (t == sumg_pkg::ucd_type_t12 && c >= 1 && c <= 6)
				check(k, sumg_pkg::burst_tlv4);
			if (t == sumg_pkg::ucd_type_t12 && k == sumg_pkg::burst_tlv5 && c >= 9 && c <= 11)
				adv = 1'b1;
			if (t == sumg_pkg::ucd_type_t3 || t == sumg_pkg::ucd_type_t4)
				check(k, sumg_pkg::burst_tlv5);
			if (t == sumg_pkg::ucd_type_t5)
				check(k, sumg_pkg::burst_tlv23);
		end
		if (t == sumg_pkg::ucd_type_t12 && us_chan_type[3 * i[1:0] +: 3] == sumg_pkg::chan_type2)
			check(adv, 1);
		if (t == sumg_pkg::ucd_type_t3)
			check(codes[1] && codes[3] && (codes[9] || codes[10] || codes[11]) && !codes[5] && !codes[6], 1);
		if (t == sumg_pkg::ucd_type_t4)
			check(codes[5] && codes[6] && codes[9] && codes[10], 1);
	endtask

	// Watch first bytes, packet position of sync bytes and completed messages.
	always @(negedge clock)
	begin
		if (out_valid && out_ready && out_first)
		begin
			in_sync = (out_data === sumg_pkg::sync_msg_type);
			first_cyc = cycles;
			id = upstream_chan_ident;
			if (in_sync)
				check({frame_control_kind, frame_control_param}, {sumg_pkg::fc_kind_mac_specific, sumg_pkg::fc_param_timing});
		end
		if (out_valid && out_ready && in_sync)
			check(mpeg_pos >= sumg_pkg::mpeg_hdr_len, 1);
		if (msg_done)
			check_msg();
	end

	// Cut a hang short.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	// Pick a round's configuration: two hand-written corners, then random ones.
	task automatic cfg(input int r);
		logic [11:0] ct;
		logic [3:0] sh;
		logic [2:0] tk;
		if (r == 0)
		begin
			{primary_capable, us_available, us_maps_here, us_chan_type} <= {1'b1, 4'hf, 4'hf, 12'haa3};
			{us_shared, change_count, shared35_value, slow} <= {4'h3, 8'h7f, 8'h01, 1'b0};
			return;
		end
		if (r == 1)
		begin
			{primary_capable, us_available, us_maps_here, slow} <= {1'b0, 4'hf, 4'h0, 1'b1};
			return;
		end
		for (int j = 0; j < 4; j++)
		begin
			lfsr = lfsr_next(lfsr);
			tk = 3'(lfsr % 5 + 1);
			ct[3 * j +: 3] = tk;
			sh[j] = lfsr[7] && (tk == 3'h3 || tk == 3'h4);
		end
		lfsr = lfsr_next(lfsr);
		{primary_capable, slow, us_available} <= {lfsr[0] | lfsr[1], lfsr[2], lfsr[7:4]};
		lfsr = lfsr_next(lfsr);
		{us_maps_here, shared35_value} <= {lfsr[3:0] | lfsr[7:4], 7'h00, lfsr[5]};
		lfsr = lfsr_next(lfsr);
		{change_count, us_chan_type, us_shared} <= {lfsr, ct, sh};
	endtask

	// Main sequence: each round resets, configures, runs and tallies.
	initial
	begin
		for (int r = 0; r < 6; r++)
		begin
			@(posedge clock);
			sys_rst <= 1'b1;
			@(posedge clock);
			cfg(r);
			repeat (19) @(posedge clock);
			sys_rst <= 1'b0;
			{seen, hint, best, n_sync, prev_cyc} = {4'h0, 4'h0, 32'h0, 32'd0, -32'sd1};
			repeat (1500) @(posedge clock);
			check(n_sync != 0, primary_capable);
			check(seen, us_available & us_maps_here);
			for (int j = 0; j < 4; j++)
			begin
				if (seen[j])
					check(best[j], exp_hdr(us_chan_type[3 * j +: 3]) >> 8);
				check(hint[j], seen[j] && us_shared[j] && us_chan_type[3 * j +: 3] == sumg_pkg::chan_type3);
			end
		end
		wrap_up();
	end
endmodule // tb
